// >>> src/pacc_pkg.sv
/*
  Package for the channel 2 configuration/status and diagnostics block.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package pacc_pkg;

  // Register byte addresses and word indexes.
  localparam logic [7:0] CFG_PRIMARY_ADDR   = 8'h30; // Module primary config word.
  localparam logic [7:0] CH2_CFG_ADDR       = 8'h38; // Printed word offset 14, times four.
  localparam logic [7:0] DIAG_STATUS_ADDR   = 8'h40; // Sticky event status, clear on read.
  localparam logic [7:0] DIAG_MASK_ADDR     = 8'h44; // Event mask.
  localparam logic [7:0] DIAG_LEVEL_ADDR    = 8'h48; // Live diagnostic levels.
  localparam logic [7:0] CH2_CFG_INDEX      = 8'h0e; // Printed word offset of the channel 2 word.
  localparam logic [7:0] ATTN_LIMIT_INDEX   = 8'h0c; // Attention below this word offset.

  // Primary configuration word fields.
  localparam int CFG_CONFIGURED_BIT = 0;
  localparam int CFG_FORCE_ERR_BIT  = 1;

  // Channel 2 word fields.
  localparam int CH2_EN_POL_BIT     = 10;
  localparam int CH2_DB_BYPASS_BIT  = 11;
  localparam int CH2_EN_LIVE_BIT    = 12;
  localparam int CH2_SRC_LSB        = 14;
  localparam int CH2_FUSE_BIT       = 6;
  localparam logic [15:0] CH2_WR_MASK = 16'hcfbc; // Bits written and read back.
  localparam logic [15:0] CH2_RESET   = 16'h0000;

  // Diagnostic event bit positions.
  localparam int EV_WDOG  = 0;
  localparam int EV_FUSE  = 1;
  localparam int EV_FORCE = 2;
  localparam int EV_WIDTH = 3;

  // Timing at 250 MHz.
  localparam int CLK_MHZ          = 250;
  localparam int DEBOUNCE_US      = 1;
  localparam int DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
  localparam int WDOG_MS_DEFAULT  = 10;
  localparam int WDOG_CYCLES_DEF  = WDOG_MS_DEFAULT * 1000 * CLK_MHZ;
  localparam int COMM_HOLD_CYCLES = 1000 * CLK_MHZ; // Lamp stays lit 1 ms after an access.
  localparam int TB_1K_CYCLES     = 1000 * CLK_MHZ / 2; // Half periods of the timebases.
  localparam int TB_10K_CYCLES    = 100 * CLK_MHZ / 2;
  localparam int TB_100K_CYCLES   = 10 * CLK_MHZ / 2;

  // Count source encodings.
  typedef enum logic [1:0] {
    SRC_EXT  = 2'b00,
    SRC_1K   = 2'b01,
    SRC_10K  = 2'b10,
    SRC_100K = 2'b11
  } count_src_t;

  // Lamps grouped for the front panel.
  typedef struct packed {
    logic       comm;
    logic       ext_fault;
    logic       int_fault;
    logic [1:0] channel_enable_lamps;
  } lamps_t;

endpackage : pacc_pkg

// >>> src/pacc_ch2_diag.sv
/*
  Channel 2 upper configuration/status bits, count source selection, enable and
  snapshot conditioning, diagnostic lamps, watchdog and error/attention flag.
  Assumes synchronous field inputs and a single APB master on pclk.
  The watchdog period is a parameter and benches set it short. Attention is
  shown as pslverr while writes still land, so the force-error bit at word
  index 12 can always be cleared again. The timebases free-run from reset.
*/
`timescale 1ns/100ps

module pacc_ch2_diag
#(
  parameter int WDOG_CYCLES = pacc_pkg::WDOG_CYCLES_DEF
)(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  input  wire logic [1:0]      enable_in,
  input  wire logic            snapshot_in,
  input  wire logic            count_in,
  input  wire logic            fuse_blown,
  output logic                 count_tick,
  output logic                 counter_run,
  output logic                 snapshot_cond,
  output logic                 error_flag,
  output logic                 irq,
  output pacc_pkg::lamps_t     lamps
);
  import pacc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01
  } bus_state_t;

  logic [15:0]         ch2_cfg;
  logic [1:0]          primary_cfg;
  logic [EV_WIDTH-1:0] ev_status;
  logic [EV_WIDTH-1:0] ev_mask;
  bus_state_t          bus_state;
  logic                en_db;
  logic                snap_db;
  logic [15:0]         en_cnt;
  logic [15:0]         snap_cnt;
  logic                en_cond;
  logic                snap_sel;
  logic [31:0]         wdog_cnt;
  logic                wdog_fault;
  logic [31:0]         comm_cnt;
  logic [19:0]         tb_cnt [3];
  logic [2:0]          tb_lvl;
  logic                src_lvl;
  logic                src_prev;
  logic                int_fault;
  logic                ext_fault;
  logic                access;
  logic                wr_en;
  logic                rd_en;
  logic [EV_WIDTH-1:0] ev_now;

  // Byte address to printed word index.
  function automatic logic [7:0] word_index(input logic [7:0] a);
    word_index = {2'b00, a[7:2]};
  endfunction : word_index

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: every access finishes in its first access cycle; the state
  // check keeps a stray penable without a setup cycle from acting.
  assign access = psel && penable && (bus_state == ST_ACCESS);
  assign wr_en  = access && pwrite;
  assign rd_en  = access && !pwrite;

  // Bus state tracks setup and access phases.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_state <= ST_IDLE;
    else if (psel && !penable)
      bus_state <= ST_ACCESS;
    else
      bus_state <= ST_IDLE;
  end

  // Configuration writes; bit 12 and bit 13 are never stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch2_cfg     <= CH2_RESET;
      primary_cfg <= 2'b00;
      ev_mask     <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == CH2_CFG_ADDR)
        ch2_cfg <= pwdata[15:0] & CH2_WR_MASK;
      if (paddr == CFG_PRIMARY_ADDR)
        primary_cfg <= pwdata[1:0];
      if (paddr == DIAG_MASK_ADDR)
        ev_mask <= pwdata[EV_WIDTH-1:0];
    end
  end

  // Sticky events; a new event wins over the read that clears.
  // Bit order follows the event positions: force error, fuse, watchdog.
  assign ev_now = {primary_cfg[CFG_FORCE_ERR_BIT], fuse_blown, wdog_fault};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_status <= '0;
    else if (rd_en && paddr == DIAG_STATUS_ADDR)
      // Only the bits returned at the setup edge are cleared, so none is lost.
      ev_status <= (ev_status & ~prdata[EV_WIDTH-1:0]) | ev_now;
    else
      ev_status <= ev_status | ev_now;
  end

  // Read data, ready and attention/error answer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable)
      begin
        if (error_flag && word_index(paddr) < ATTN_LIMIT_INDEX)
          pslverr <= 1'b1;
        else if (!pwrite)
        begin
          case (paddr)
            CH2_CFG_ADDR:
              prdata <= {16'h0000, ch2_cfg[15:14], 1'b0, en_cond, ch2_cfg[11:7],
                         fuse_blown, ch2_cfg[5:0]};
            CFG_PRIMARY_ADDR: prdata <= {30'h0, primary_cfg};
            DIAG_STATUS_ADDR: prdata <= {29'h0, ev_status};
            DIAG_MASK_ADDR:   prdata <= {29'h0, ev_mask};
            DIAG_LEVEL_ADDR:  prdata <= {29'h0, ev_now};
            default:          pslverr <= 1'b1;
          endcase
        end
        else if (paddr != CH2_CFG_ADDR && paddr != CFG_PRIMARY_ADDR &&
                 paddr != DIAG_MASK_ADDR)
          pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce of enable and snapshot, bypassable.
  // A new level must hold for the debounce count before the filtered copy follows.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_db    <= 1'b0;
      en_cnt   <= '0;
    end
    else if (enable_in[1] == en_db)
      en_cnt <= '0;
    else if (en_cnt == 16'(DEBOUNCE_CYCLES - 1))
    begin
      en_db  <= enable_in[1];
      en_cnt <= '0;
    end
    else
      en_cnt <= en_cnt + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_db  <= 1'b0;
      snap_cnt <= '0;
    end
    else if (snapshot_in == snap_db)
      snap_cnt <= '0;
    else if (snap_cnt == 16'(DEBOUNCE_CYCLES - 1))
    begin
      snap_db  <= snapshot_in;
      snap_cnt <= '0;
    end
    else
      snap_cnt <= snap_cnt + 16'h0001;
  end

  assign en_cond  = ch2_cfg[CH2_DB_BYPASS_BIT] ? enable_in[1] : en_db;
  assign snap_sel = ch2_cfg[CH2_DB_BYPASS_BIT] ? snapshot_in  : snap_db;

  // Run and snapshot outputs to the counter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_run   <= 1'b0;
      snapshot_cond <= 1'b0;
    end
    else
    begin
      counter_run   <= en_cond ^ ch2_cfg[CH2_EN_POL_BIT];
      snapshot_cond <= snap_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal timebases as square waves.
  localparam int TB_HALF [3] = '{TB_1K_CYCLES, TB_10K_CYCLES, TB_100K_CYCLES};
  for (genvar g = 0; g < 3; g++)
  begin : g_tb
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        tb_cnt[g] <= '0;
        tb_lvl[g] <= 1'b0;
      end
      else if (tb_cnt[g] == 20'(TB_HALF[g] - 1))
      begin
        tb_cnt[g] <= '0;
        tb_lvl[g] <= ~tb_lvl[g];
      end
      else
        tb_cnt[g] <= tb_cnt[g] + 20'h00001;
    end
  end

  // Source select and one-cycle tick on rising edge of the source.
  // A change of source can give one false tick, so users skip a few cycles.
  always_comb
  begin
    case (count_src_t'(ch2_cfg[15:14]))
      SRC_EXT:  src_lvl = count_in;
      SRC_1K:   src_lvl = tb_lvl[0];
      SRC_10K:  src_lvl = tb_lvl[1];
      SRC_100K: src_lvl = tb_lvl[2];
      default:  src_lvl = count_in;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_prev   <= 1'b0;
      count_tick <= 1'b0;
    end
    else
    begin
      src_prev   <= src_lvl;
      count_tick <= src_lvl && !src_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, restarted by any access.
  // The timeout fault holds until the next access, which is what clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdog_cnt   <= '0;
      wdog_fault <= 1'b0;
    end
    else if (access)
    begin
      wdog_cnt   <= '0;
      wdog_fault <= 1'b0;
    end
    else if (wdog_cnt == 32'(WDOG_CYCLES - 1))
      wdog_fault <= 1'b1;
    else
      wdog_cnt <= wdog_cnt + 32'h1;
  end

  // Communications activity hold.
  // The hold keeps the lamp visible between sparse polls of the controller.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      comm_cnt <= '0;
    else if (access)
      comm_cnt <= 32'(COMM_HOLD_CYCLES);
    else if (comm_cnt != '0)
      comm_cnt <= comm_cnt - 32'h1;
  end

  assign int_fault = primary_cfg[CFG_FORCE_ERR_BIT] || wdog_fault;
  assign ext_fault = fuse_blown;

  // Lamps, error flag and interrupt.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lamps      <= '0;
      error_flag <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      lamps.comm                 <= access || comm_cnt != '0;
      lamps.ext_fault            <= ext_fault;
      lamps.int_fault            <= int_fault;
      lamps.channel_enable_lamps <= {en_cond, enable_in[0]};
      error_flag                 <= int_fault || ext_fault;
      irq                        <= |(ev_status & ev_mask);
    end
  end

endmodule : pacc_ch2_diag

// >>> bench/pacc_sva.sv
/* Port assertions for the channel 2 diagnostics block.
   Assumes one clock pclk and the asynchronous low reset presetn. */
`timescale 1ns/100ps
module pacc_sva
  import pacc_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic            pready,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  input wire logic            fuse_blown,
  input wire logic            count_tick,
  input wire logic            error_flag,
  input wire pacc_pkg::lamps_t lamps
);
  // All properties share the bus clock and reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A completed bus transfer.
  wire logic acc = psel && penable && pready;
  //////////////////////////////////////////////////////////////////////////////
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("Access cycle without ready.");
  AST_COMM: assert property (acc |-> ##[1:2] lamps.comm)
    else $error("Comm lamp dark after access.");
  AST_EXT_ON: assert property (fuse_blown [*3] |-> lamps.ext_fault)
    else $error("External fault lamp dark.");
  AST_EXT_OFF: assert property (!fuse_blown [*3] |-> !lamps.ext_fault)
    else $error("External fault lamp lit.");
  AST_ERR_ON: assert property ((lamps.int_fault || lamps.ext_fault) [*3] |-> error_flag)
    else $error("Error flag low with a fault.");
  AST_ERR_OFF: assert property (!(lamps.int_fault || lamps.ext_fault) [*3] |-> !error_flag)
    else $error("Error flag high without fault.");
  AST_ATTN: assert property (acc && error_flag && $past(error_flag) && paddr < 8'h30 |-> pslverr)
    else $error("No attention reply.");
  AST_RD13: assert property (acc && !pwrite && paddr == CH2_CFG_ADDR |-> prdata[13] == 1'b0)
    else $error("Unused bit read as one.");
  AST_TICK: assert property (count_tick |=> !count_tick)
    else $error("Count tick longer than one cycle.");
endmodule : pacc_sva

// >>> bench/ctrl_model.sv
/* Behavioural system controller that reaches the block over APB.
   Assumes a slave that answers within sixteen access cycles. */
`timescale 1ns/100ps
module ctrl_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  logic hung;
  // Idle bus at time zero.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // One transfer: setup, then access held until ready at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : ctrl_model

// >>> bench/tb.sv
/* Self-checking bench for the channel 2 diagnostics block.
   Assumes the controller model carries all bus traffic. */
`timescale 1ns/100ps
module tb;
  import pacc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, m;
  logic [1:0]  enable_in;
  logic        snapshot_in, count_in, fuse_blown, count_tick, counter_run;
  logic        snapshot_cond, error_flag, irq;
  lamps_t      lamps;
  int          bad_count, comparisons, seed, n, t0, t1, i, j, k, s;
  int          win [4] = '{100, 2600, 55000, 5600};
  //////////////////////////////////////////////////////////////////////////////
  // Bus clock with a 4 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Block under test with a short watchdog, and the controller model.
  pacc_ch2_diag #(.WDOG_CYCLES(50)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .enable_in, .snapshot_in, .count_in,
    .fuse_blown, .count_tick, .counter_run, .snapshot_cond, .error_flag, .irq, .lamps);
  ctrl_model u_ctl (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  //////////////////////////////////////////////////////////////////////////////
  // Compares a seen value with an expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // One bus transfer; a hung bus ends the run.
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_ctl.xfer(w, a, d, q, e);
    if (u_ctl.hung)
    begin
      bad_count++;
      $display("Error at %0t: bus hang", $time);
      report_and_stop();
    end
  endtask : rw
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc
  // Counts ticks over a window and keeps the last two tick times.
  task automatic ticks(input int w);
    n = 0;
    for (i = 0; i < w; i++)
    begin
      @(posedge pclk);
      if (count_tick === 1'b1)
      begin
        n++;
        t0 = t1;
        t1 = i;
      end
    end
  endtask : ticks
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    seed = 83;
    presetn = 1'b0;
    enable_in = 2'b00;
    snapshot_in = 1'b0;
    count_in = 1'b0;
    fuse_blown = 1'b0;
    cyc(8);
    presetn <= 1'b1;
    cyc(1);
    chk({error_flag, irq, lamps}, 0);
    rw(1'b0, CH2_CFG_ADDR, 0);
    chk(q, CH2_RESET);
    $display("reset test done");
    for (j = 0; j < 4; j++)
    begin
      m = $random(seed);
      enable_in <= m[17:16];
      rw(1'b1, CH2_CFG_ADDR, m);
      cyc(300);
      rw(1'b0, CH2_CFG_ADDR, 0);
      chk(q, {16'h0, m[15:0] & CH2_WR_MASK} | {19'h0, m[17], 12'h0});
      chk(e, 0);
      chk(counter_run, m[17] ^ m[10]);
      chk(lamps.channel_enable_lamps, m[17:16]);
      chk(lamps.comm, 1);
    end
    $display("register test done");
    enable_in <= 2'b00;
    rw(1'b1, CH2_CFG_ADDR, 0);
    cyc(300);
    enable_in <= 2'b10;
    snapshot_in <= 1'b1;
    cyc(20);
    chk({counter_run, snapshot_cond}, 0);
    cyc(300);
    chk({counter_run, snapshot_cond}, 3);
    rw(1'b1, CH2_CFG_ADDR, 32'h800);
    enable_in <= 2'b00;
    snapshot_in <= 1'b0;
    cyc(6);
    chk({counter_run, snapshot_cond}, 0);
    $display("debounce test done");
    for (s = 0; s < 4; s++)
    begin
      rw(1'b1, CH2_CFG_ADDR, s << 14);
      cyc(10);
      k = ($random(seed) & 7) + 1;
      fork
        ticks(win[s]);
        for (j = 0; j < (s == 0 ? k : 0); j++)
        begin
          count_in <= 1'b1;
          cyc(4);
          count_in <= 1'b0;
          cyc(4);
        end
      join
      if (s == 0) chk(n, k);
      if (s == 1) chk(n <= 1, 1);
      if (s > 1) chk(t1 - t0, CLK_MHZ * (s == 2 ? 100 : 10));
    end
    $display("source test done");
    fuse_blown <= 1'b1;
    cyc(4);
    chk({lamps.ext_fault, error_flag}, 3);
    rw(1'b0, 8'h04, 0);
    chk(e, 1);
    rw(1'b0, CH2_CFG_ADDR, 0);
    chk({e, q[6]}, 1);
    fuse_blown <= 1'b0;
    rw(1'b1, CFG_PRIMARY_ADDR, 32'h3);
    cyc(3);
    chk(lamps.int_fault, 1);
    rw(1'b1, CFG_PRIMARY_ADDR, 32'h1);
    cyc(3);
    chk(lamps.int_fault, 0);
    cyc(80);
    chk({lamps.int_fault, error_flag}, 3);
    rw(1'b0, CH2_CFG_ADDR, 0);
    chk(e, 0);
    cyc(3);
    chk(lamps.int_fault, 0);
    $display("fault test done");
    rw(1'b1, DIAG_MASK_ADDR, 0);
    cyc(2);
    m[0] = irq;
    rw(1'b1, DIAG_MASK_ADDR, 32'h7);
    cyc(2);
    chk({m[0], irq}, 1);
    rw(1'b0, DIAG_STATUS_ADDR, 0);
    chk(q[EV_FUSE], 1);
    rw(1'b0, DIAG_STATUS_ADDR, 0);
    chk(q[EV_FUSE], 0);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule : tb
// Checker attached to every instance of the block.
bind pacc_ch2_diag pacc_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .prdata, .pslverr, .fuse_blown, .count_tick, .error_flag, .lamps);
